// >>> core/conv_seq_consts.svh
// Constants for the conversion sequencer: offsets, fields, timing
`ifndef CONV_SEQ_CONSTS_SVH
`define CONV_SEQ_CONSTS_SVH
`define OFF_CONTROL_ZERO   12'h000
`define OFF_PRESCALER      12'h004
`define OFF_CHAIN          12'h008
`define OFF_INJECTION      12'h00c
`define OFF_POWER          12'h010
`define OFF_THR_HIGH0      12'h014
`define OFF_THR_LOW0       12'h024
`define OFF_PENDING        12'h034
`define OFF_IMASK          12'h038
`define OFF_DMA_ENABLE     12'h03c
`define OFF_DMA_MASK       12'h040
`define OFF_DATA0          12'h050
`define OFF_DATA_LAST      12'h08c
`define SAMPLE_PERIODS     5'd10
`define CONVERT_PERIODS    5'd20
`define CAL_PERIODS        5'd20
`define PEND_EOC           4'd0
`define PEND_ECH           4'd1
`define PEND_END_OF_INJECTED_CONVERSION_IRQ          4'd2
`define PEND_END_OF_INJECTED_CHAIN_IRQ          4'd3
`define PEND_WDG_BASE      4'd4
`endif

// >>> core/conv_seq_pkg.sv
// Types shared by the conversion sequencer
package conv_seq_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_SAMPLE, ST_CONVERT} phase_t;
    typedef struct packed {
        logic [1:0]  cr0;           // Calibrate, start
        logic        sampling_prescaler_enable;          // Sampling prescaler enable
        logic [2:0]  conversion_prescaler;          // Active conversion prescaler
        logic [2:0]  sampling_prescaler;          // Active sampling prescaler
        logic        pre_pend;      // Held prescaler write waiting
        logic [6:0]  pre_hold;      // Held sampling_prescaler_enable, conversion_prescaler, sampling_prescaler
        logic        mode;          // Scan mode
        logic [3:0]  first_channel_field;           // Software first channel
        logic [3:0]  channel_count_field;           // Software count minus one
        logic [3:0]  cur_ch;        // Live normal channel
        logic [3:0]  cur_n;         // Live normal remaining count
        logic        chain_act;     // Normal chain in progress
        logic        stop_req;      // Scan stop asked, chain still finishing
        logic        injection_start;        // Injection start
        logic [3:0]  injected_first_channel;
        logic [3:0]  injected_channel_count;
        logic [3:0]  jcur_ch;
        logic [3:0]  jcur_n;
        logic        inj_act;       // Injected chain running
        logic        analog_power_down;          // Analog power down
        logic        auto_clock_off;          // Auto clock off
        logic        noavrg;        // Calibration average off
        logic [3:0][15:0] thr_a;    // Guarded channel and high limit
        logic [3:0][15:0] thr_b;    // Enable and low limit
        logic [11:0] pend;          // Pending bits
        logic [11:0] imask;         // Interrupt mask
        logic        dma_en;        // Global DMA enable
        logic [15:0] dma_mask;      // Per-channel DMA mask
        logic [15:0][9:0] data;     // Channel results
        phase_t      phase;
        logic [3:0]  div_cnt;       // Prescaler divider count
        logic [4:0]  per_cnt;       // Analog periods in this phase
        logic [31:0] prdata;
        logic        pready;
        logic        irq;
        logic        dma_req;
        logic [3:0]  dma_ch;
        logic        aclk_en;       // Analog clock tick enable
        logic        sample;        // Sampling phase indicator
        logic        soc;           // Start of conversion pulse
        logic [3:0]  mux_ch;        // Channel to the input mux
        logic [2:0]  res_s1;        // Three-stage result-ready sync
    } state_t;
endpackage

// >>> core/conv_seq.sv
// Control logic of the 10-bit 16-input successive-approximation converter
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "conv_seq_consts.svh"
module conv_seq
    import conv_seq_pkg::*;
#(
    parameter int NUM_CH = 16               // Available input channels
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  analog_result,  // Result from the analog core
    input  wire logic        analog_done,    // Result valid, analog core domain
    output logic             analog_clk_en,  // Analog clock tick
    output logic             analog_sample,  // Sampling phase
    output logic             analog_soc,     // Conversion start pulse
    output logic             analog_calib,   // Calibration running
    output logic             analog_pd,      // Analog power down
    output logic      [3:0]  analog_channel, // Input mux select
    output logic             irq,
    output logic             dma_req,
    output logic      [3:0]  dma_channel
);
    state_t s_ff, nxt_s;                    // Whole block state

    // Division factor of a prescaler code
    function automatic logic [3:0] div_of(input logic [2:0] code);
        div_of = (code == 3'h0) ? 4'h1 : {code, 1'b0};
    endfunction

    // Force an out-of-range channel field to zero
    function automatic logic [3:0] clip(input logic [3:0] v);
        clip = ({28'h0, v} > NUM_CH - 1) ? 4'h0 : v;
    endfunction

    // Next channel with wrap past the highest one
    function automatic logic [3:0] next_ch(input logic [3:0] c);
        next_ch = ({28'h0, c} >= NUM_CH - 1) ? 4'h0 : c + 4'h1;
    endfunction

    logic done_edge;                        // Synchronised analog_done high in two stages, masked by pend[11]
    assign done_edge = s_ff.res_s1[1] & s_ff.res_s1[2] & ~s_ff.pend[11]
                       & 1'b1;

    // Next state: bus, sequencing, clocks, flags
    always_comb
    begin
        logic        wr, rd, busy, tick, eoc, fin, run_inj;
        logic [3:0]  div, ch;
        logic [31:0] rv;
        nxt_s = s_ff;
        wr = psel & penable & pwrite & ~s_ff.pready;
        rd = psel & penable & ~pwrite & ~s_ff.pready;
        nxt_s.pready = psel & penable & ~s_ff.pready;
        nxt_s.soc = 1'b0;
        nxt_s.dma_req = 1'b0;
        nxt_s.res_s1 = {s_ff.res_s1[1:0], analog_done};
        eoc = 1'b0;
        fin = 1'b0;
        run_inj = s_ff.inj_act;
        ch = run_inj ? s_ff.jcur_ch : s_ff.cur_ch;
        // Analog clock divider; calibration uses the conversion prescaler
        div = (s_ff.phase == ST_SAMPLE && s_ff.sampling_prescaler_enable) ? div_of(s_ff.sampling_prescaler)
                                                     : div_of(s_ff.conversion_prescaler);
        tick = (s_ff.div_cnt + 4'h1 >= div);
        nxt_s.div_cnt = tick ? 4'h0 : s_ff.div_cnt + 4'h1;
        busy = (s_ff.phase != ST_IDLE);
        nxt_s.aclk_en = tick & (busy | ~s_ff.auto_clock_off) & ~s_ff.analog_power_down;
        // Phase machine
        case (s_ff.phase)
            ST_IDLE:
            begin
                nxt_s.per_cnt = 5'h0;
                if (s_ff.cr0[1] && !s_ff.analog_power_down)
                    nxt_s.phase = ST_CAL;
                else if ((s_ff.injection_start || s_ff.cr0[0]) && !s_ff.analog_power_down)
                begin
                    // Calibration takes priority; start waits here
                    if (s_ff.injection_start && !s_ff.inj_act)
                    begin
                        nxt_s.inj_act = 1'b1;
                        nxt_s.jcur_ch = s_ff.injected_first_channel;
                        nxt_s.jcur_n = s_ff.injected_channel_count;
                        ch = s_ff.injected_first_channel;
                    end
                    else if (!s_ff.chain_act && !s_ff.injection_start)
                    begin
                        nxt_s.chain_act = 1'b1;
                        nxt_s.cur_ch = s_ff.first_channel_field;
                        nxt_s.cur_n = s_ff.channel_count_field;
                        ch = s_ff.first_channel_field;
                    end
                    nxt_s.mux_ch = ch;
                    nxt_s.phase = ST_SAMPLE;
                    nxt_s.soc = 1'b1;
                end
            end
            ST_CAL:
            begin
                if (tick)
                    nxt_s.per_cnt = s_ff.per_cnt + 5'h1;
                if (tick && s_ff.per_cnt + 5'h1 >= `CAL_PERIODS)
                begin
                    nxt_s.cr0[1] = 1'b0;      // Cleared only by hardware
                    nxt_s.phase = ST_IDLE;
                end
            end
            ST_SAMPLE:
            begin
                if (tick)
                    nxt_s.per_cnt = s_ff.per_cnt + 5'h1;
                if (tick && s_ff.per_cnt + 5'h1 >= `SAMPLE_PERIODS)
                begin
                    nxt_s.per_cnt = 5'h0;
                    nxt_s.phase = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (tick)
                    nxt_s.per_cnt = s_ff.per_cnt + 5'h1;
                if (tick && s_ff.per_cnt + 5'h1 >= `CONVERT_PERIODS)
                begin
                    eoc = 1'b1;
                    nxt_s.per_cnt = 5'h0;
                    nxt_s.phase = ST_IDLE;
                end
            end
            default: nxt_s.phase = ST_IDLE;
        endcase
        // Injection pre-empts a normal conversion in progress
        if (s_ff.injection_start && !s_ff.inj_act && !run_inj &&
            (s_ff.phase == ST_SAMPLE || s_ff.phase == ST_CONVERT))
        begin
            nxt_s.phase = ST_IDLE;
            eoc = 1'b0;
        end
        // End of one channel conversion
        if (eoc)
        begin
            nxt_s.data[ch] = analog_result;
            if (s_ff.dma_mask[ch] && s_ff.dma_en)
            begin
                nxt_s.dma_req = 1'b1;
                nxt_s.dma_ch = ch;
            end
            for (int w = 0; w < 4; w++)
                if (s_ff.thr_b[w][15] && s_ff.thr_a[w][13:10] == ch)
                begin
                    // Below low or above high sets its pending bit
                    if (analog_result < s_ff.thr_b[w][9:0])
                        nxt_s.pend[`PEND_WDG_BASE + 4'(2 * w)] = 1'b1;
                    if (analog_result > s_ff.thr_a[w][9:0])
                        nxt_s.pend[`PEND_WDG_BASE + 4'(2 * w) + 4'h1] = 1'b1;
                end
            if (run_inj)
            begin
                nxt_s.pend[`PEND_END_OF_INJECTED_CONVERSION_IRQ] = 1'b1;
                nxt_s.jcur_ch = next_ch(s_ff.jcur_ch);
                nxt_s.jcur_n = s_ff.jcur_n - 4'h1;
                if (s_ff.jcur_n == 4'h0)
                begin
                    nxt_s.pend[`PEND_END_OF_INJECTED_CHAIN_IRQ] = 1'b1;
                    nxt_s.inj_act = 1'b0;
                    nxt_s.injection_start = 1'b0;      // Resume normal chain
                end
            end
            else
            begin
                nxt_s.pend[`PEND_EOC] = 1'b1;
                nxt_s.cur_ch = next_ch(s_ff.cur_ch);
                nxt_s.cur_n = s_ff.cur_n - 4'h1;
                if (s_ff.cur_n == 4'h0)
                begin
                    fin = 1'b1;
                    nxt_s.pend[`PEND_ECH] = 1'b1;
                    nxt_s.chain_act = 1'b0;   // Fields restored
                    if (!s_ff.mode)
                        nxt_s.cr0[0] = 1'b0;  // One shot done
                end
            end
        end
        // Scan stop: chain finishes, then start clears; one-shot ignores
        if (fin && s_ff.mode && s_ff.stop_req)
        begin
            nxt_s.cr0[0] = 1'b0;
            nxt_s.stop_req = 1'b0;
        end
        // Held prescaler write lands once start and calibrate are idle
        if (s_ff.pre_pend && s_ff.cr0 == 2'b00 && !busy)
        begin
            {nxt_s.sampling_prescaler_enable, nxt_s.conversion_prescaler, nxt_s.sampling_prescaler} = s_ff.pre_hold;
            nxt_s.pre_pend = 1'b0;
        end
        // Register writes
        if (wr)
        begin
            case (paddr)
                `OFF_CONTROL_ZERO:
                begin
                    if (pwdata[1]) nxt_s.cr0[1] = 1'b1;  // Abort impossible
                    if (pwdata[0])
                    begin
                        nxt_s.cr0[0] = 1'b1;
                        nxt_s.stop_req = 1'b0;
                    end
                    // Scan stop is only noted; one-shot ignores the clear
                    else if (s_ff.mode && s_ff.cr0[0])
                        nxt_s.stop_req = 1'b1;
                end
                `OFF_PRESCALER:
                begin
                    nxt_s.pre_hold = {pwdata[15], pwdata[7:5], pwdata[2:0]};
                    nxt_s.pre_pend = 1'b1;
                end
                `OFF_CHAIN:
                begin
                    nxt_s.mode = pwdata[15];
                    nxt_s.first_channel_field = clip(pwdata[3:0]);
                    nxt_s.channel_count_field = clip(pwdata[9:6]);
                end
                `OFF_INJECTION:
                begin
                    if (pwdata[15]) nxt_s.injection_start = 1'b1;
                    nxt_s.injected_first_channel = clip(pwdata[3:0]);
                    nxt_s.injected_channel_count = clip(pwdata[9:6]);
                end
                `OFF_POWER:
                begin
                    nxt_s.analog_power_down = pwdata[15];
                    nxt_s.auto_clock_off = pwdata[14];
                    nxt_s.noavrg = pwdata[5];
                end
                `OFF_PENDING:
                    // Only a one-hot word clears; set in same cycle wins unless the bit was already pending
                    if ($onehot(pwdata[11:0]) && pwdata[31:12] == 20'h0)
                        nxt_s.pend = nxt_s.pend & ~(pwdata[11:0] & s_ff.pend);
                `OFF_IMASK:      nxt_s.imask = pwdata[11:0];
                `OFF_DMA_ENABLE: nxt_s.dma_en = pwdata[15];
                `OFF_DMA_MASK:   nxt_s.dma_mask = pwdata[15:0];
                default:
                    for (int w = 0; w < 4; w++)
                    begin
                        if (paddr == `OFF_THR_HIGH0 + 12'(4 * w))
                            nxt_s.thr_a[w] = {2'b00, pwdata[13:0]};
                        if (paddr == `OFF_THR_LOW0 + 12'(4 * w))
                            nxt_s.thr_b[w] = {pwdata[15], 5'h0, pwdata[9:0]};
                    end
            endcase
        end
        // Power down at once stops the phase machine and clears start, calibrate, injection and stop request
        if (s_ff.analog_power_down)
        begin
            nxt_s.phase = ST_IDLE;
            nxt_s.cr0 = 2'b00;
            nxt_s.injection_start = 1'b0;
            nxt_s.inj_act = 1'b0;
            nxt_s.chain_act = 1'b0;
            nxt_s.stop_req = 1'b0;
            nxt_s.soc = 1'b0;
        end
        // Read mux
        rv = 32'h0;
        case (paddr)
            `OFF_CONTROL_ZERO: rv = {30'h0, s_ff.cr0};
            `OFF_PRESCALER:    rv = {16'h0, s_ff.sampling_prescaler_enable, 7'h0, s_ff.conversion_prescaler, 2'h0, s_ff.sampling_prescaler};
            `OFF_CHAIN:        rv = s_ff.chain_act
                ? {16'h0, s_ff.mode, 5'h0, s_ff.cur_n, 2'h0, s_ff.cur_ch}
                : {16'h0, s_ff.mode, 5'h0, s_ff.channel_count_field, 2'h0, s_ff.first_channel_field};
            `OFF_INJECTION:    rv = {16'h0, s_ff.injection_start, 5'h0, s_ff.injected_channel_count, 2'h0, s_ff.injected_first_channel};
            `OFF_POWER:        rv = {16'h0, s_ff.analog_power_down, s_ff.auto_clock_off, 8'h0, s_ff.noavrg, 5'h0};
            `OFF_PENDING:      rv = {20'h0, s_ff.pend};
            `OFF_IMASK:        rv = {20'h0, s_ff.imask};
            `OFF_DMA_ENABLE:   rv = {16'h0, s_ff.dma_en, 11'h0, s_ff.dma_ch};
            `OFF_DMA_MASK:     rv = {16'h0, s_ff.dma_mask};
            default:
            begin
                for (int w = 0; w < 4; w++)
                begin
                    if (paddr == `OFF_THR_HIGH0 + 12'(4 * w)) rv = {16'h0, s_ff.thr_a[w]};
                    if (paddr == `OFF_THR_LOW0 + 12'(4 * w))  rv = {16'h0, s_ff.thr_b[w]};
                end
                for (int c = 0; c < 16; c++)
                    if (paddr == `OFF_DATA0 + 12'(4 * c)) rv = {22'h0, s_ff.data[c]};
            end
        endcase
        if (rd) nxt_s.prdata = rv;
        nxt_s.irq = |(nxt_s.pend & s_ff.imask);
        nxt_s.sample = (nxt_s.phase == ST_SAMPLE);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
            s_ff.analog_power_down <= 1'b1;        // Powered down after reset
            s_ff.phase <= ST_IDLE;
        end
        else
            s_ff <= nxt_s;
    end

    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = 1'b0 & s_ff.pready;
    assign analog_clk_en = s_ff.aclk_en;
    assign analog_sample = s_ff.sample;
    assign analog_soc = s_ff.soc;
    assign analog_calib = s_ff.cr0[1] & (s_ff.phase == ST_CAL);
    assign analog_pd = s_ff.analog_power_down;
    assign analog_channel = s_ff.mux_ch;
    assign irq = s_ff.irq;
    assign dma_req = s_ff.dma_req;
    assign dma_channel = s_ff.dma_ch;
endmodule // conv_seq

// >>> verification/conv_seq_checker.sv
// Port-level assertion checker for the conversion sequencer
`timescale 1ns/1ps
module conv_seq_checker
    import conv_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic analog_clk_en,
    input wire logic analog_sample,
    input wire logic analog_soc,
    input wire logic analog_calib,
    input wire logic analog_pd,
    input wire logic dma_req
);
    typedef struct packed
    {
        logic [5:0] cal_cnt;    // Ticks seen in this calibration
        logic [5:0] smp_cnt;    // Ticks seen in this sampling phase
    } chk_state_t;
    chk_state_t state_ff;       // Registered counters
    chk_state_t nxt_state;      // Next counters
    // Count ticks per phase; a new start clears the sample count
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.cal_cnt = analog_calib ? state_ff.cal_cnt + {5'h0, analog_clk_en} : 6'h0;
        nxt_state.smp_cnt = (analog_sample && !analog_soc) ?
                            state_ff.smp_cnt + {5'h0, analog_clk_en} : 6'h0;
    end
    // Counters clear on reset so a second reset starts clean
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_pd_held; analog_pd [*3]; endsequence
    property p_answer; s_access |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held too long");
    property p_no_err; !pslverr; endproperty
    a_no_err: assert property (p_no_err) else $error("slave error raised");
    property p_pd_block; s_pd_held |-> !analog_soc && !analog_calib; endproperty
    a_pd_block: assert property (p_pd_block) else $error("activity in power down");
    property p_pd_abort; $rose(analog_pd) |-> ##[0:2] (!analog_sample && !analog_calib); endproperty
    a_pd_abort: assert property (p_pd_abort) else $error("power down did not abort");
    property p_cal_wait; analog_calib |-> !analog_soc; endproperty
    a_cal_wait: assert property (p_cal_wait) else $error("start during calibration");
    property p_cal_clk; analog_calib |-> !analog_sample; endproperty
    a_cal_clk: assert property (p_cal_clk) else $error("sampling during calibration");
    property p_smp_len; analog_sample |-> state_ff.smp_cnt <= 6'd10; endproperty
    a_smp_len: assert property (p_smp_len) else $error("sampling phase too long");
    property p_cal_len;
        $fell(analog_calib) && !analog_pd |-> state_ff.cal_cnt inside {[6'd19:6'd20]};
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_dma; dma_req |=> !dma_req; endproperty
    a_dma: assert property (p_dma) else $error("dma request not a pulse");
endmodule // conv_seq_checker

// >>> verification/analog_core_model.sv
// Behavioural model of the analog converter core and input mux
`timescale 1ns/1ps
module analog_core_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       analog_sample,
    input  wire logic [3:0] analog_channel,
    output logic      [9:0] analog_result,
    output logic            analog_done
);
    logic [3:0] held_ch_ff;  // Channel seen while sampling
    logic       busy_ff;     // Some conversion has begun
    // Track the sampled channel; the result depends on it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_ch_ff <= 4'h0;
            busy_ff <= 1'b0;
        end
        else if (analog_sample)
        begin
            held_ch_ff <= analog_channel;
            busy_ff <= 1'b1;
        end
    end
    // While sampling or before any sample the bus shows the inverse; after a conversion it holds the value
    assign analog_result = (busy_ff && !analog_sample) ? {held_ch_ff, 6'h25} : ~{held_ch_ff, 6'h25};
    assign analog_done = busy_ff && !analog_sample;
endmodule // analog_core_model

// >>> verification/testbench.sv
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0]  ares;
    logic        adone, clk_en, smp, soc, cal, pd, irq, dreq;
    logic [3:0]  ach, dch;
    int          fail_count = 0, cmp_count = 0, socs = 0, dmas = 0, ticks = 0, g;
    int          fact[8] = '{1, 2, 4, 6, 8, 10, 12, 14}; // Division per prescaler code
    // Free-running 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    conv_seq #(.NUM_CH(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .analog_result(ares), .analog_done(adone),
        .analog_clk_en(clk_en), .analog_sample(smp), .analog_soc(soc), .analog_calib(cal),
        .analog_pd(pd), .analog_channel(ach), .irq(irq), .dma_req(dreq), .dma_channel(dch));
    analog_core_model u_core (.pclk(pclk), .presetn(presetn), .analog_sample(smp),
        .analog_channel(ach), .analog_result(ares), .analog_done(adone));
    // Event counters for the scenarios below
    always @(posedge pclk)
    begin
        socs <= socs + (soc === 1'b1);
        dmas <= dmas + (dreq === 1'b1);
        ticks <= ticks + (clk_en === 1'b1);
    end
    task automatic end_of_test();
        $display("Counts: %0d compared, %0d bad", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100)
        begin
            chk("pready", 32'h0, 32'h1);
            end_of_test();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask
    // Poll until the masked bits read zero; a hang ends the run
    task automatic wait_clear(input logic [11:0] a, input logic [31:0] m);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        while ((q & m) !== 32'h0 && n < 3000);
        if (n >= 3000)
        begin
            chk("busy bit", q & m, 32'h0);
            end_of_test();
        end
    endtask
    // Leaves in g the cycles between two ticks of the chosen phase
    task automatic gap(input logic s);
        for (int k = 0; k < 2; k++)
        begin
            g = 0;
            do
            begin
                @(posedge pclk);
                g++;
            end
            while (!(clk_en === 1'b1 && smp === s) && g < 5000);
        end
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h010, 32'h8000, "power control");
        chk("power down pin", {31'h0, pd}, 32'h1);
        rd(12'h100, 32'h0, "unmapped");
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'h3);
        apb(1'b1, 12'h000, 32'h3);
        rd(12'h000, 32'h3, "calibrating");
        wait_clear(12'h000, 32'h2);
        wait_clear(12'h000, 32'h1);
        rd(12'h05c, {22'h0, 4'h3, 6'h25}, "data 3");
        $display("Test calibration done");
        // Every code alone, then the sampling prescaler enabled
        for (int r = 0; r < 9; r++)
        begin
            apb(1'b1, 12'h004, r < 8 ? r << 5 : 32'h8023);
            apb(1'b1, 12'h000, 32'h1);
            gap(1'b1);
            chk("sample gap", g, r < 8 ? fact[r] : 6);
            gap(1'b0);
            chk("convert gap", g, r < 8 ? fact[r] : 2);
            wait_clear(12'h000, 32'h1);
        end
        apb(1'b1, 12'h004, 32'h0);
        $display("Test prescalers done");
        apb(1'b1, 12'h034, 32'h1);
        apb(1'b1, 12'h034, 32'h2);
        rd(12'h034, 32'h0, "pending cleared");
        apb(1'b1, 12'h038, 32'h3);
        apb(1'b1, 12'h040, 32'h8001);
        apb(1'b1, 12'h03c, 32'h8000);
        apb(1'b1, 12'h008, 32'hce);
        apb(1'b1, 12'h000, 32'h1);
        wait_clear(12'h000, 32'h1);
        for (int c = 14; c < 18; c++)
            rd(12'h050 + 12'((c % 16) * 4), {22'h0, 4'(c % 16), 6'h25}, "wrap data");
        rd(12'h058, 32'h0, "data 2");
        chk("dma pulses", dmas, 2);
        chk("dma channel", {28'h0, dch}, 32'h0);
        rd(12'h034, 32'h3, "pending");
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, 12'h034, 32'h3);
        rd(12'h034, 32'h3, "pending kept");
        apb(1'b1, 12'h034, 32'h1);
        rd(12'h034, 32'h2, "pending one");
        apb(1'b1, 12'h038, 32'h0);
        rd(12'h034, 32'h2, "pending masked");
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd(12'h008, 32'hce, "chain restored");
        $display("Test chain done");
        apb(1'b1, 12'h040, 32'h0);
        apb(1'b1, 12'h014, 32'h1500);
        apb(1'b1, 12'h024, 32'h8000);
        apb(1'b1, 12'h008, 32'h8005);
        apb(1'b1, 12'h000, 32'h1);
        g = socs + 3;
        for (int n = 0; n < 3000 && socs < g; n++)
            @(posedge pclk);
        chk("scan repeats", socs >= g, 32'h1);
        apb(1'b1, 12'h00c, 32'h8009);
        wait_clear(12'h00c, 32'h8000);
        rd(12'h074, {22'h0, 4'h9, 6'h25}, "injected data");
        apb(1'b0, 12'h034, 32'h0);
        chk("injected flags", q & 32'hc, 32'hc);
        chk("watchdog above", q & 32'h30, 32'h20);
        apb(1'b1, 12'h000, 32'h0);
        wait_clear(12'h000, 32'h1);
        g = socs;
        repeat (200) @(posedge pclk);
        chk("scan stopped", socs, g);
        rd(12'h064, {22'h0, 4'h5, 6'h25}, "scan data");
        $display("Test scan done");
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h010, 32'h8000);
        g = socs;
        repeat (200) @(posedge pclk);
        chk("powered down", socs, g);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h010, 32'h4000);
        g = ticks;
        repeat (100) @(posedge pclk);
        chk("clock gated", ticks, g);
        $display("Test power done");
        end_of_test();
    end
endmodule // testbench
bind conv_seq conv_seq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .analog_clk_en(analog_clk_en),
    .analog_sample(analog_sample), .analog_soc(analog_soc), .analog_calib(analog_calib),
    .analog_pd(analog_pd), .dma_req(dma_req));
